// ### card_slot_model.sv
// Removable card model driving the slot pins
`timescale 1ns/1ns
module card_slot_model (
    input wire clk, // Clock
    input wire inserted, // Card in the slot
    input wire locked, // Card is protected
    output reg card_present_in = 1'b0, // Detect and program pin
    output reg card_protected_in = 1'b0 // Protection pin
);
    // Empty slot reads low, contacts are pulled down
    always @(posedge clk) card_present_in <= inserted;
    always @(posedge clk) card_protected_in <= inserted & locked;
endmodule

// ### run_stop_control.v
// Run/stop startup controller with cycle engine and cycle-rate monitor
`timescale 1ns/1ns
`include "run_stop_defines.vh"
module run_stop_control #(
    parameter GATE_CYCLES = `GATE_TIME_S * `CLK_FREQ_HZ, // Gate length in clocks
    parameter COPY_CYCLES = 16, // Card copy duration in clocks
    parameter CNT_W = 32 // Counter width
) (
    input wire clk, // 250 MHz clock
    input wire reset, // Async reset, active high
    input wire [3:0] wb_adr_i, // Word address
    input wire [31:0] wb_dat_i, // Write data
    output reg [31:0] wb_dat_o, // Read data
    input wire [3:0] wb_sel_i, // Byte selects
    input wire wb_we_i, // Write enable
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    output reg wb_ack_o, // Acknowledge
    input wire mem_valid_in, // Stored validity flag of internal memory
    input wire card_present_in, // Card detect pin
    input wire card_valid_in, // Card holds a program
    input wire card_protected_in, // Card is know-how protected
    output reg copy_active, // Card-to-memory copy in progress
    output reg erase_pulse, // Erase internal program
    output reg sample_inputs, // Input sampling phase
    output reg eval_program, // Evaluation phase
    output reg update_outputs, // Output update phase
    output reg marker, // Inverted marker
    output wire lamp_red, // Red status lamp
    output wire lamp_green // Green status lamp
);
    wire card_lvl;
    wire pvld_lvl;
    wire prot_lvl;
    wire mvld_lvl;
    reg card_r;
    reg [1:0] state_r;
    reg [1:0] phase_r;
    reg boot_r;
    reg [3:0] boot_cnt_r;
    reg loaded_r;
    reg [31:0] copy_cnt_r;
    reg [CNT_W-1:0] gate_cnt_r;
    reg [CNT_W-1:0] per_cnt_r;
    reg [CNT_W-1:0] rate_r;
    reg [31:0] password_r;
    reg [31:0] key_r;
    reg prot_seen_r;
    wire wr;
    wire rd;
    wire wr_ctrl;
    wire ctrl_start;
    wire ctrl_stop;
    wire ctrl_loaded;
    wire wr_pw;
    wire wr_key;
    wire period_end;
    wire card_now;
    wire unlocked;

    // A write lands only at the edge where the master sees ack high
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign wr_ctrl = wr & (wb_adr_i == `ADR_CTRL) & wb_sel_i[0];
    assign ctrl_start = wr_ctrl & wb_dat_i[`CTRL_START];
    assign ctrl_stop = wr_ctrl & wb_dat_i[`CTRL_STOP];
    assign ctrl_loaded = wr_ctrl & wb_dat_i[`CTRL_LOADED];
    assign wr_pw = wr & (wb_adr_i == `ADR_PASSWORD);
    assign wr_key = wr & (wb_adr_i == `ADR_PWKEY);
    // Marker just fell: one full marker period has passed
    assign period_end = update_outputs & ~marker;
    assign card_now = card_lvl;
    assign unlocked = ~prot_seen_r | (key_r == password_r);
    assign lamp_red = (state_r != `ST_RUN);
    assign lamp_green = (state_r == `ST_RUN);

    // Slot and memory pins are asynchronous; each level settles after four clocks
    pin_filter #(
        .RESET_LEVEL(1'b0)
    ) pres_filter (
        .clk(clk),
        .reset(reset),
        .pin(card_present_in),
        .level(card_lvl)
    );

    pin_filter #(
        .RESET_LEVEL(1'b0)
    ) pvld_filter (
        .clk(clk),
        .reset(reset),
        .pin(card_valid_in),
        .level(pvld_lvl)
    );

    pin_filter #(
        .RESET_LEVEL(1'b0)
    ) prot_filter (
        .clk(clk),
        .reset(reset),
        .pin(card_protected_in),
        .level(prot_lvl)
    );

    pin_filter #(
        .RESET_LEVEL(1'b0)
    ) mvld_filter (
        .clk(clk),
        .reset(reset),
        .pin(mem_valid_in),
        .level(mvld_lvl)
    );

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            card_r <= 1'b0;
        end else begin
            card_r <= card_now;
        end
    end

    // Run/stop sequencer; no local button exists, so boot, host and a protected-card pull steer it
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= `ST_STOP;
            boot_r <= 1'b1;
            boot_cnt_r <= 4'h0;
            loaded_r <= 1'b0;
            copy_cnt_r <= 32'h0;
            copy_active <= 1'b0;
            erase_pulse <= 1'b0;
            prot_seen_r <= 1'b0;
        end else begin
            erase_pulse <= 1'b0;
            if (boot_r) begin
                // Wait for the synchronisers to fill before deciding
                boot_cnt_r <= boot_cnt_r + 4'h1;
                if (boot_cnt_r == `BOOT_WAIT) begin
                    boot_r <= 1'b0;
                    if (card_now && pvld_lvl) begin
                        state_r <= `ST_COPY;
                        copy_active <= 1'b1;
                        copy_cnt_r <= 32'h0;
                        prot_seen_r <= prot_lvl;
                    end else if (mvld_lvl) begin
                        loaded_r <= 1'b1;
                        state_r <= `ST_RUN;
                    end else begin
                        state_r <= `ST_STOP;
                    end
                end
            end else begin
                case (state_r)
                    `ST_COPY: begin
                        copy_cnt_r <= copy_cnt_r + 32'h1;
                        if (copy_cnt_r == COPY_CYCLES - 1) begin
                            copy_active <= 1'b0;
                            loaded_r <= 1'b1;
                            state_r <= `ST_RUN;
                        end
                    end
                    `ST_RUN: begin
                        if (ctrl_stop) begin
                            state_r <= `ST_STOP;
                        end
                    end
                    `ST_STOP: begin
                        // Host start after download
                        if (ctrl_start && loaded_r) begin
                            state_r <= `ST_RUN;
                        end
                    end
                    default: state_r <= `ST_STOP;
                endcase
                if (ctrl_loaded) begin
                    loaded_r <= 1'b1;
                    prot_seen_r <= 1'b0;
                end
                // Protected card pulled: program is wiped, block stops, even mid-copy
                if (prot_seen_r && card_r && !card_now) begin
                    erase_pulse <= 1'b1;
                    copy_active <= 1'b0;
                    loaded_r <= 1'b0;
                    prot_seen_r <= 1'b0;
                    state_r <= `ST_STOP;
                end
            end
        end
    end

    // Three-phase program cycle, only while running
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= `PH_INPUT;
            sample_inputs <= 1'b0;
            eval_program <= 1'b0;
            update_outputs <= 1'b0;
            marker <= 1'b0;
        end else begin
            sample_inputs <= 1'b0;
            eval_program <= 1'b0;
            update_outputs <= 1'b0;
            if (state_r == `ST_RUN) begin
                case (phase_r)
                    `PH_INPUT: begin
                        sample_inputs <= 1'b1;
                        phase_r <= `PH_EVAL;
                    end
                    `PH_EVAL: begin
                        eval_program <= 1'b1;
                        phase_r <= `PH_OUTPUT;
                    end
                    `PH_OUTPUT: begin
                        update_outputs <= 1'b1;
                        marker <= ~marker;
                        phase_r <= `PH_INPUT;
                    end
                    default: phase_r <= `PH_INPUT;
                endcase
            end else begin
                phase_r <= `PH_INPUT;
            end
        end
    end

    // Rate monitor: a period is counted on each falling marker edge, except one on the clock where the gate count restarts
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            gate_cnt_r <= {CNT_W{1'b0}};
            per_cnt_r <= {CNT_W{1'b0}};
            rate_r <= {CNT_W{1'b0}};
        end else if (gate_cnt_r == GATE_CYCLES - 1) begin
            gate_cnt_r <= {CNT_W{1'b0}};
            rate_r <= per_cnt_r;
            per_cnt_r <= {CNT_W{1'b0}};
        end else begin
            gate_cnt_r <= gate_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            if (period_end)
                per_cnt_r <= per_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Wishbone slave, one registered ack per request
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            password_r <= 32'h0;
            key_r <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wr_pw) begin
                password_r <= wb_dat_i;
            end
            if (wr_key) begin
                key_r <= wb_dat_i;
            end
            wb_dat_o <= 32'h0;
            if (rd) begin
                case (wb_adr_i)
                    `ADR_CTRL: wb_dat_o <= {28'h0, prot_seen_r, loaded_r, 2'h0};
                    `ADR_STATUS: wb_dat_o <= {24'h0, marker, copy_active, card_r,
                        unlocked, lamp_green, lamp_red, state_r};
                    `ADR_RATE: begin
                        // Live data only in run and only when unlocked
                        if (state_r == `ST_RUN && unlocked)
                            wb_dat_o <= rate_r[31:0];
                    end
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule

// Three-stage pin synchroniser; the level moves only when the last two stages agree
module pin_filter #(
    parameter [0:0] RESET_LEVEL = 1'b0 // Level held during reset
) (
    input wire clk, // Clock
    input wire reset, // Async reset, active high
    input wire pin, // Asynchronous pin
    output reg level // Filtered level
);
    reg [2:0] stage_r;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_r <= {3{RESET_LEVEL}};
            level <= RESET_LEVEL;
        end else begin
            stage_r <= {stage_r[1:0], pin};
            if (stage_r[1] == stage_r[2])
                level <= stage_r[2];
        end
    end
endmodule

// ### run_stop_control_asserts.sv
// Concurrent checks on the run/stop controller ports
`timescale 1ns/1ns
module run_stop_control_asserts (
    input wire clk, // Clock
    input wire reset, // Reset
    input wire wb_ack_o, // Ack
    input wire [31:0] wb_dat_o, // Read data
    input wire copy_active, // Copying
    input wire erase_pulse, // Erase
    input wire sample_inputs, // Phase 1
    input wire eval_program, // Phase 2
    input wire update_outputs, // Phase 3
    input wire marker, // Per-cycle marker
    input wire lamp_red, // Red lamp
    input wire lamp_green // Green lamp
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_LAMPS: assert property (lamp_red != lamp_green) else $error("lamp mix");
    AST_EVAL: assert property (eval_program |-> $past(sample_inputs)) else $error("order");
    AST_UPD: assert property (update_outputs |-> $past(eval_program)) else $error("order");
    AST_RUN_ONLY: assert property (sample_inputs |-> lamp_green || $past(lamp_green))
        else $error("cycle while idle");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data");
    AST_ERASE: assert property (erase_pulse |-> ##[0:3] lamp_red) else $error("no stop");
    AST_COPY: assert property (copy_active |-> lamp_red) else $error("copy runs");
    AST_MARK_FLIP: assert property (update_outputs |-> marker != $past(marker))
        else $error("marker did not flip");
    AST_MARK_HOLD: assert property (!update_outputs |-> $stable(marker))
        else $error("marker moved mid cycle");
    cover property (copy_active);
    cover property (erase_pulse);
    cover property (sample_inputs);
endmodule
bind run_stop_control run_stop_control_asserts chk (.clk, .reset, .wb_ack_o, .wb_dat_o,
    .copy_active, .erase_pulse, .sample_inputs, .eval_program, .update_outputs,
    .marker, .lamp_red, .lamp_green);

// ### run_stop_control_tb.sv
// Self-checking bench for the run/stop controller
`timescale 1ns/1ns
`include "run_stop_defines.vh"
module run_stop_control_tb;
    localparam GATE = 300;
    localparam COPY = 16;
    reg clk = 1'b0, reset = 1'b1, we = 1'b0, cyc = 1'b0;
    reg ins = 1'b0, prot = 1'b0, memv = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wdat = 32'h0, lfsr = 32'h0001_2894, r;
    wire [31:0] rdat;
    wire ack, cp, cl, copy, erase, red, grn;
    integer n_errors = 0, n_tests = 0, ncopy = 0, nerase = 0, i;
    run_stop_control #(.GATE_CYCLES(GATE), .COPY_CYCLES(COPY)) dut (.clk(clk), .reset(reset),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hF), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .mem_valid_in(memv),
        .card_present_in(cp), .card_valid_in(cp), .card_protected_in(cl), .copy_active(copy),
        .erase_pulse(erase), .sample_inputs(), .eval_program(), .update_outputs(),
        .marker(), .lamp_red(red), .lamp_green(grn));
    card_slot_model slot (.clk(clk), .inserted(ins), .locked(prot),
        .card_present_in(cp), .card_protected_in(cl));
    initial forever #2 clk = ~clk;
    always @(posedge clk) ncopy <= ncopy + (copy === 1'b1);
    always @(posedge clk) nerase <= nerase + (erase === 1'b1);
    function [31:0] nx(input [31:0] l);
        nx = {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        n_errors = n_errors + (seen !== exp);
    endtask
    task bus(input w, input [3:0] a, input [31:0] d);
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        // No cycle count assumed; only the watchdog ends a hung wait
        while (ack !== 1'b1) @(posedge clk);
        r = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task stat(input [1:0] s);
        bus(1'b0, `ADR_STATUS, 32'h0);
        check(r[3:0], {s == `ST_RUN, s != `ST_RUN, s});
        check({grn, red}, {s == `ST_RUN, s != `ST_RUN});
    endtask
    task power_on(input [2:0] cfg);
        {reset, ins, prot, memv} <= {1'b1, cfg};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task print_verdict(input integer extra);
        n_errors = n_errors + extra;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Sequence needs about 1500 cycles, 5000 is ample
    initial #20000 print_verdict(1);
    initial begin
        power_on(3'h0);
        bus(1'b1, `ADR_CTRL, 32'h1);
        stat(`ST_STOP);
        bus(1'b0, 4'hF, 32'h0);
        check(r, 32'h0);
        power_on(3'h1);
        stat(`ST_RUN);
        repeat (2 * GATE + 12) @(posedge clk);
        bus(1'b0, `ADR_RATE, 32'h0);
        // Gate edges may cut off one marker period
        check((r + 32'h1) / 32'h2, GATE / 12);
        i = ncopy;
        power_on(3'h5);
        repeat (COPY + 4) @(posedge clk);
        check(ncopy - i, COPY);
        stat(`ST_RUN);
        power_on(3'h6);
        // Let a whole gate pass in run so a locked read has real data to hide
        repeat (2 * GATE + 12) @(posedge clk);
        lfsr = nx(lfsr);
        bus(1'b1, `ADR_PASSWORD, lfsr);
        bus(1'b0, `ADR_RATE, 32'h0);
        check(r, 32'h0);
        bus(1'b1, `ADR_PWKEY, lfsr);
        bus(1'b0, `ADR_STATUS, 32'h0);
        check(r[4], 32'h1);
        bus(1'b0, `ADR_RATE, 32'h0);
        check((r + 32'h1) / 32'h2, GATE / 12);
        i = nerase;
        ins <= 1'b0;
        repeat (8) @(posedge clk);
        check(nerase - i, 32'h1);
        bus(1'b1, `ADR_CTRL, 32'h4);
        bus(1'b1, `ADR_CTRL, 32'h1);
        stat(`ST_RUN);
        bus(1'b0, `ADR_CTRL, 32'h0);
        check(r, 32'h4);
        bus(1'b1, `ADR_CTRL, 32'h2);
        stat(`ST_STOP);
        print_verdict(0);
    end
endmodule

// ### run_stop_defines.vh
// Constants for the run/stop startup controller
`ifndef RUN_STOP_DEFINES_VH
`define RUN_STOP_DEFINES_VH

`define CLK_FREQ_HZ 250000000
`define GATE_TIME_S 2
`define BOOT_WAIT 4'h4

`define ADR_CTRL 4'h0
`define ADR_STATUS 4'h1
`define ADR_RATE 4'h2
`define ADR_PASSWORD 4'h3
`define ADR_PWKEY 4'h4

`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_LOADED 2
`define CTRL_PROT 3

`define ST_STOP 2'h0
`define ST_COPY 2'h1
`define ST_RUN 2'h2

`define PH_INPUT 2'h0
`define PH_EVAL 2'h1
`define PH_OUTPUT 2'h2

`endif
